/* rtl/mtc_cfg.svh */
// Register offsets, field positions, reset values and timing constants of the misc timer bank.
`ifndef MTC_CFG_SVH
`define MTC_CFG_SVH

`define MTC_AW              8
`define MTC_OFF_TIMER_CFG   8'h8C
`define MTC_OFF_TIMER_CNT   8'h90
`define MTC_OFF_BYTE_ORDER  8'h98
`define MTC_OFF_TICK_COUNT  8'h9C
`define MTC_OFF_DROP_COUNT  8'hA0
`define MTC_OFF_IND_CMD     8'hA4
`define MTC_OFF_IND_DATA    8'hA8
`define MTC_OFF_HOST_WIDTH  8'hB0

`define MTC_BIT_TIMER_RUN   29
`define MTC_BIT_PENDING     31
`define MTC_BIT_DIRECTION   30
`define MTC_BIT_HOST16      0

`define MTC_TIMER_ONES      16'hFFFF
`define MTC_ORDER_BIG       32'hFFFF_FFFF
`define MTC_DROP_HALF_LO    32'h7FFF_FFFF
`define MTC_ZERO16          16'h0000
`define MTC_ZERO32          32'h0000_0000
`define MTC_ONE32           32'h0000_0001

`define MTC_TICK_CLR_NS     160

`endif

/* rtl/mtc_pkg.sv */
// Types shared by the misc timer and counter register bank.
package mtc_pkg;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_REQ,
        HS_REL
    } mtc_hs_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } mtc_mac_req_t;

    typedef struct packed {
        logic         gpt_run;
        logic [15:0]  timer_preload_field;
        logic [15:0]  timer_current_value;
        logic [31:0]  order;
        logic         host16;
        logic         big16;
        logic [31:0]  tick_cnt;
        logic [31:0]  tick_snap;
        logic         tick_held;
        logic [31:0]  drop_cnt;
        logic         pending;
        logic         dir_read;
        logic [7:0]   cmd_addr;
        logic [31:0]  mac_data;
        mtc_hs_t      hs;
        logic         ack_s1;
        logic         ack_s2;
        logic         ack_s3;
        logic         pready;
        logic         pslverr;
        logic [31:0]  prdata;
        logic         timer_evt;
        logic         drop_evt;
        mtc_mac_req_t mac;
    } mtc_state_t;

endpackage

/* rtl/mtc_regs.sv */
// APB register bank with timer, tick counter, drop counter and indirect MAC access.
`timescale 1ns/1ps
`include "mtc_cfg.svh"
//
// Functional notes
// - Run bit set starts timer, clear halts it
// - Run falling edge forces preload to all ones
// - Preload is low sixteen bits, resets ones
// - Current count readable, resets to all ones
// - Timer raises periodic interrupt events
// - All-ones order word selects big-endian
// - Byte order matters only in 16-bit mode
// - Tick counter 32 bits, zero, increments
// - Tick counter wraps to zero, keeps counting
// - 16-bit reads latch count on first half
// - Tick counter clear may lag reset briefly
// - Tick counter runs in every power state
// - Drop counter counts discarded frames, resets zero
// - Reading drop counter clears it
// - Midpoint crossing of drop counter flags event
// - Pending bit starts transfer, self-clears when done
// - Read data valid once pending clears
// - Direction bit one reads, zero writes
// - Low byte selects MAC register, resets zero
// - Separate data register, resets zero
module mtc_regs (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic [31:0]               prdata,
    input  wire logic                 tick_en,
    input  wire logic                 rx_frame_dropped,
    output logic                      timer_event,
    output logic                      drop_half_event,
    output logic                      big_endian_16,
    output mtc_pkg::mtc_mac_req_t     mac_req,
    input  wire logic                 mac_ack,
    input  wire logic [31:0]          mac_rdata
);

    localparam mtc_pkg::mtc_state_t ST_RST = '{
        timer_preload_field : `MTC_TIMER_ONES,
        timer_current_value  : `MTC_TIMER_ONES,
        hs       : mtc_pkg::HS_IDLE,
        default  : '0
    };

    mtc_pkg::mtc_state_t q;
    mtc_pkg::mtc_state_t d;

    // True when the address is one of the mapped words.
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `MTC_OFF_TIMER_CFG,
            `MTC_OFF_TIMER_CNT,
            `MTC_OFF_BYTE_ORDER,
            `MTC_OFF_TICK_COUNT,
            `MTC_OFF_DROP_COUNT,
            `MTC_OFF_IND_CMD,
            `MTC_OFF_IND_DATA,
            `MTC_OFF_HOST_WIDTH: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction

    // Read view of a register, taken in the setup cycle.
    function automatic logic [31:0] read_word(input mtc_pkg::mtc_state_t s,
                                              input logic [7:0] a);
        logic [31:0] w;
        w = `MTC_ZERO32;
        case (a)
            `MTC_OFF_TIMER_CFG: begin
                w[15:0] = s.timer_preload_field;
                w[`MTC_BIT_TIMER_RUN] = s.gpt_run;
            end
            `MTC_OFF_TIMER_CNT: begin
                w[15:0] = s.timer_current_value;
            end
            `MTC_OFF_BYTE_ORDER: begin
                w = s.order;
            end
            `MTC_OFF_TICK_COUNT: begin
                // Second half of a split read sees the held copy.
                w = s.tick_held ? s.tick_snap : s.tick_cnt;
            end
            `MTC_OFF_DROP_COUNT: begin
                w = s.drop_cnt;
            end
            `MTC_OFF_IND_CMD: begin
                w[`MTC_BIT_PENDING] = s.pending;
                w[`MTC_BIT_DIRECTION] = s.dir_read;
                w[7:0] = s.cmd_addr;
            end
            `MTC_OFF_IND_DATA: begin
                w = s.mac_data;
            end
            `MTC_OFF_HOST_WIDTH: begin
                w[`MTC_BIT_HOST16] = s.host16;
            end
            default: begin
                w = `MTC_ZERO32;
            end
        endcase
        return w;
    endfunction

    logic        setup;
    logic        access;
    logic        wr_acc;
    logic        rd_acc;
    logic        ack_hi;
    logic        ack_lo;
    logic        run_new;
    logic [31:0] drop_base;

    always_comb begin
        d = q;
        d.pready = 1'b0;
        d.timer_evt = 1'b0;
        d.drop_evt = 1'b0;

        setup = psel & ~penable;
        access = psel & penable & q.pready;
        wr_acc = access & pwrite;
        rd_acc = access & ~pwrite;
        run_new = pwdata[`MTC_BIT_TIMER_RUN];

        // The first stage only feeds the second; the decision uses stages two and three.
        d.ack_s1 = mac_ack;
        d.ack_s2 = q.ack_s1;
        d.ack_s3 = q.ack_s2;
        ack_hi = q.ack_s2 & q.ack_s3;
        ack_lo = ~q.ack_s2 & ~q.ack_s3;

        // Answer is prepared during setup so that every APB output is a flop.
        if (setup) begin
            d.pready = 1'b1;
            d.pslverr = ~is_mapped(paddr);
            d.prdata = pwrite ? `MTC_ZERO32 : read_word(q, paddr);
        end

        // Free-running counter never gates on power state or register writes.
        if (tick_en) begin
            d.tick_cnt = q.tick_cnt + `MTC_ONE32;
        end

        // Timer decrements only while running.
        if (q.gpt_run && tick_en) begin
            if (q.timer_current_value == `MTC_ZERO16) begin
                d.timer_current_value = q.timer_preload_field;
                d.timer_evt = 1'b1;
            end else begin
                d.timer_current_value = q.timer_current_value - 16'h0001;
            end
        end

        if (wr_acc && paddr == `MTC_OFF_TIMER_CFG) begin
            d.gpt_run = run_new;
            d.timer_preload_field = pwdata[15:0];
            if (q.gpt_run && !run_new) begin
                d.timer_preload_field = `MTC_TIMER_ONES;
            end
            if (!q.gpt_run && run_new) begin
                d.timer_current_value = pwdata[15:0];
            end
        end

        if (wr_acc && paddr == `MTC_OFF_BYTE_ORDER) begin
            d.order = pwdata;
        end
        if (wr_acc && paddr == `MTC_OFF_HOST_WIDTH) begin
            d.host16 = pwdata[`MTC_BIT_HOST16];
        end
        // Order word is ignored unless the host bus is 16 bits wide.
        d.big16 = d.host16 & (d.order == `MTC_ORDER_BIG);

        // Latch on the first half, release on the second; 32-bit hosts see live counts.
        if (rd_acc && paddr == `MTC_OFF_TICK_COUNT) begin
            if (q.host16 && !q.tick_held) begin
                d.tick_snap = q.prdata;
                d.tick_held = 1'b1;
            end else begin
                d.tick_held = 1'b0;
            end
        end

        // Subtracting only what was reported keeps drops between setup and access.
        drop_base = q.drop_cnt;
        if (rd_acc && paddr == `MTC_OFF_DROP_COUNT) begin
            drop_base = q.drop_cnt - q.prdata;
        end
        if (rx_frame_dropped) begin
            d.drop_cnt = drop_base + `MTC_ONE32;
            if (drop_base == `MTC_DROP_HALF_LO) begin
                d.drop_evt = 1'b1;
            end
        end else begin
            d.drop_cnt = drop_base;
        end

        // Writes during a pending transfer are dropped to protect the request.
        if (wr_acc && paddr == `MTC_OFF_IND_CMD && !q.pending) begin
            d.dir_read = pwdata[`MTC_BIT_DIRECTION];
            d.cmd_addr = pwdata[7:0];
            d.pending = pwdata[`MTC_BIT_PENDING];
        end
        if (wr_acc && paddr == `MTC_OFF_IND_DATA && !q.pending) begin
            d.mac_data = pwdata;
        end

        // Four-phase handshake toward the MAC register space.
        case (q.hs)
            mtc_pkg::HS_IDLE: begin
                if (q.pending) begin
                    d.mac.req = 1'b1;
                    d.mac.write = ~q.dir_read;
                    d.mac.addr = q.cmd_addr;
                    d.mac.wdata = q.mac_data;
                    d.hs = mtc_pkg::HS_REQ;
                end
            end
            mtc_pkg::HS_REQ: begin
                if (ack_hi) begin
                    d.mac.req = 1'b0;
                    if (q.dir_read) begin
                        d.mac_data = mac_rdata;
                    end
                    d.hs = mtc_pkg::HS_REL;
                end
            end
            mtc_pkg::HS_REL: begin
                if (ack_lo) begin
                    d.pending = 1'b0;
                    d.hs = mtc_pkg::HS_IDLE;
                end
            end
            default: begin
                d.mac.req = 1'b0;
                d.hs = mtc_pkg::HS_IDLE;
            end
        endcase
    end

    // The tick counter clears at once under reset, well inside the allowed lag.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign prdata = q.prdata;
    assign timer_event = q.timer_evt;
    assign drop_half_event = q.drop_evt;
    assign big_endian_16 = q.big16;
    assign mac_req = q.mac;

endmodule

/* sim/mtc_mac_model.sv */
// Behavioural MAC register space that answers the indirect handshake.
`timescale 1ns/1ps
module mtc_mac_model (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire mtc_pkg::mtc_mac_req_t mac_req,
    input  wire logic [3:0]            dly,
    output logic                       mac_ack,
    output logic [31:0]                mac_rdata
);
    logic [31:0] mem [256];
    logic [3:0]  n_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mac_ack   <= 1'b0;
            n_q       <= 4'h0;
            mac_rdata <= 32'h0000_0000;
        end else if (mac_req.req && !mac_ack) begin
            n_q <= n_q + 4'h1;
            if (n_q == dly) begin
                mac_ack   <= 1'b1;
                mac_rdata <= mem[mac_req.addr];
                if (mac_req.write)
                    mem[mac_req.addr] <= mac_req.wdata;
            end
        end else if (!mac_req.req) begin
            mac_ack <= 1'b0;
            n_q     <= 4'h0;
            // Released data toggles so that a late capture cannot match by luck.
            mac_rdata <= ~mac_rdata;
        end
    end
endmodule

/* sim/mtc_regs_sva.sv */
// Port checker for the misc timer register bank.
`timescale 1ns/1ps
`include "mtc_cfg.svh"
module mtc_regs_sva (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [7:0]            paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pready,
    input wire logic                  tick_en,
    input wire logic                  timer_event,
    input wire logic                  rx_frame_dropped,
    input wire logic                  drop_half_event,
    input wire logic                  big_endian_16,
    input wire mtc_pkg::mtc_mac_req_t mac_req,
    input wire logic                  mac_ack
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic        wr;
    logic        cmd_wr;
    logic        run_q;
    logic [31:0] cmd_q;
    assign wr = psel && penable && pready && pwrite;
    assign cmd_wr = wr && paddr == `MTC_OFF_IND_CMD && pwdata[`MTC_BIT_PENDING];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
            cmd_q <= 32'h0000_0000;
        end else begin
            if (wr && paddr == `MTC_OFF_TIMER_CFG)
                run_q <= pwdata[`MTC_BIT_TIMER_RUN];
            if (cmd_wr)
                cmd_q <= pwdata;
        end
    end
    timer_cause_a: assert property (timer_event |-> $past(tick_en))
        else $error("timer event without a tick");
    halt_quiet_a: assert property (!run_q [*3] |-> !timer_event)
        else $error("timer event while halted");
    order_little_a: assert property (wr && paddr == `MTC_OFF_BYTE_ORDER
        && pwdata != `MTC_ORDER_BIG |-> ##2 !big_endian_16)
        else $error("big endian without all ones");
    width_full_a: assert property (wr && paddr == `MTC_OFF_HOST_WIDTH
        && !pwdata[`MTC_BIT_HOST16] |-> ##2 !big_endian_16)
        else $error("big endian in full width mode");
    req_hold_a: assert property (mac_req.req && !mac_ack |=> mac_req.req)
        else $error("request dropped before acknowledge");
    req_release_a: assert property ($fell(mac_req.req) |-> mac_ack && $past(mac_ack, 2))
        else $error("request released too early");
    req_stable_a: assert property (mac_req.req && $past(mac_req.req) |-> $stable(mac_req))
        else $error("request fields moved");
    req_start_a: assert property (cmd_wr && !mac_req.req |-> ##[1:3] mac_req.req)
        else $error("command did not start a transfer");
    dir_addr_a: assert property ($rose(mac_req.req) |-> mac_req.addr == cmd_q[7:0]
        && mac_req.write == !cmd_q[`MTC_BIT_DIRECTION])
        else $error("wrong direction or address");
    drop_half_cause_a: assert property (drop_half_event |-> $past(rx_frame_dropped))
        else $error("midpoint event without a dropped frame");
    cover property (timer_event);
    cover property ($fell(mac_req.req));
    cover property (big_endian_16);
endmodule
bind mtc_regs mtc_regs_sva u_mtc_regs_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .tick_en, .timer_event, .rx_frame_dropped, .drop_half_event,
    .big_endian_16, .mac_req, .mac_ack);

/* sim/mtc_regs_tb_top.sv */
// Self-checking bench for the misc timer register bank.
`timescale 1ns/1ps
`include "mtc_cfg.svh"
module mtc_regs_tb_top;
    logic                  pclk, pready, pslverr, timer_event, big_endian_16, mac_ack, er;
    logic                  presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic                  tick_en = 1'b0, rx_frame_dropped = 1'b0, tick_on = 1'b0;
    logic                  drop_half_event, half_seen = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [3:0]            dly = 4'h0;
    logic [31:0]           pwdata = 32'h0, cyc = 32'h0, tk = 32'h0, gap = 32'h0;
    logic [31:0]           ttot = 32'h0, prdata, mac_rdata, rd, a;
    int                    miscompares = 0, tests_run = 0;
    mtc_pkg::mtc_mac_req_t mac_req;
    mtc_regs u_mtc_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .pslverr, .prdata, .tick_en, .rx_frame_dropped, .timer_event, .drop_half_event,
        .big_endian_16, .mac_req, .mac_ack, .mac_rdata);
    mtc_mac_model u_mtc_mac_model (.pclk, .presetn, .mac_req, .dly, .mac_ack, .mac_rdata);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Ticks every fourth cycle; the bench counts them to predict both counters.
    always @(posedge pclk) begin
        cyc     <= cyc + 32'h1;
        tick_en <= tick_on && cyc[1:0] == 2'h0;
        if (tick_en)
            ttot <= ttot + 32'h1;
        tk <= tick_en ? tk + 32'h1 : tk;
        if (drop_half_event === 1'b1)
            half_seen <= 1'b1;
        if (timer_event) begin
            gap <= tk;
            tk  <= 32'h0;
        end
        if (cyc == 32'h0000_1388) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= ad;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdc(input logic [7:0] ad, input logic [31:0] e);
        apb(1'b0, ad, 32'h0);
        chk($sformatf("reg %h", ad), rd, e);
    endtask
    task automatic mac(input logic [31:0] c);
        int n;
        n = 0;
        apb(1'b1, `MTC_OFF_IND_CMD, c);
        apb(1'b0, `MTC_OFF_IND_CMD, 32'h0);
        chk("busy set", {31'h0, rd[31]}, 32'h1);
        while (rd[31] !== 1'b0 && n < 40) begin
            apb(1'b0, `MTC_OFF_IND_CMD, 32'h0);
            n++;
        end
        chk("busy clear", {31'h0, rd[31]}, 32'h0);
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(`MTC_OFF_TIMER_CFG, 32'h0000_FFFF);
        rdc(`MTC_OFF_TIMER_CNT, 32'h0000_FFFF);
        rdc(`MTC_OFF_BYTE_ORDER, 32'h0);
        rdc(`MTC_OFF_TICK_COUNT, 32'h0);
        rdc(`MTC_OFF_IND_CMD, 32'h0);
        rdc(`MTC_OFF_IND_DATA, 32'h0);
        apb(1'b0, 8'hF0, 32'h0);
        chk("unmapped error", {31'h0, er}, 32'h1);
        $display("test reset values done");
        apb(1'b1, `MTC_OFF_TIMER_CFG, 32'h2000_0003);
        tick_on <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("timer period", gap, 32'h4);
        apb(1'b1, `MTC_OFF_TIMER_CFG, 32'h0000_0003);
        rdc(`MTC_OFF_TIMER_CFG, 32'h0000_FFFF);
        apb(1'b0, `MTC_OFF_TIMER_CNT, 32'h0);
        a = rd;
        repeat (20) @(posedge pclk);
        rdc(`MTC_OFF_TIMER_CNT, a);
        $display("test timer done");
        tick_on <= 1'b0;
        repeat (4) @(posedge pclk);
        rdc(`MTC_OFF_TICK_COUNT, ttot);
        apb(1'b1, `MTC_OFF_HOST_WIDTH, 32'h1);
        tick_on <= 1'b1;
        apb(1'b0, `MTC_OFF_TICK_COUNT, 32'h0);
        a = rd;
        repeat (9) @(posedge pclk);
        rdc(`MTC_OFF_TICK_COUNT, a);
        $display("test tick counter done");
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, `MTC_OFF_HOST_WIDTH, {31'h0, i != 1});
            apb(1'b1, `MTC_OFF_BYTE_ORDER, i == 2 ? 32'hFFFF_FFFE : `MTC_ORDER_BIG);
            repeat (2) @(posedge pclk);
            chk("big endian", {31'h0, big_endian_16}, {31'h0, i == 0});
        end
        $display("test byte order done");
        repeat (5) begin
            rx_frame_dropped <= 1'b1;
            @(posedge pclk);
            rx_frame_dropped <= 1'b0;
            @(posedge pclk);
        end
        rdc(`MTC_OFF_DROP_COUNT, 32'h5);
        rdc(`MTC_OFF_DROP_COUNT, 32'h0);
        // Five drops from zero never pass the midpoint, so no event may appear.
        chk("drop half event", {31'h0, half_seen}, 32'h0);
        $display("test drop counter done");
        apb(1'b1, `MTC_OFF_IND_DATA, 32'hC0DE_1234);
        mac(32'h8000_0042);
        apb(1'b1, `MTC_OFF_IND_DATA, 32'h0);
        dly <= 4'h7;
        mac(32'hC000_0042);
        rdc(`MTC_OFF_IND_DATA, 32'hC0DE_1234);
        rdc(`MTC_OFF_IND_CMD, 32'h4000_0042);
        $display("test indirect access done");
        wrap_up();
    end
endmodule
